// [include/lds_defines.svh]
`ifndef LDS_DEFINES_SVH
`define LDS_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define LDS_ADDR_CHIP_CONTROL 8'h00
`define LDS_ADDR_SPREAD_SETUP 8'h19
`define LDS_CHIP_CONTROL_RESET 8'h00
`define LDS_SPREAD_SETUP_RESET 8'h00

// ****************************************
// field positions
// ****************************************
`define LDS_RUN_BIT 0
`define LDS_RANGE_LSB 0
`define LDS_RANGE_MSB 1
`define LDS_SPREAD_EN_BIT 7

// ****************************************
// spread spans in percent
// ****************************************
`define LDS_SPAN_0 6'h05
`define LDS_SPAN_1 6'h0F
`define LDS_SPAN_2 6'h18
`define LDS_SPAN_3 6'h22

// ****************************************
// serial framing and channel count
// ****************************************
`define LDS_CMD_READ_BIT 7
`define LDS_LAST_BIT 3'h7
`define LDS_BYTE_CMD 2'h0
`define LDS_BYTE_ADDR 2'h1
`define LDS_BYTE_DATA 2'h2
`define LDS_CHANNELS 18

`endif

// [include/lds_pkg.sv]
package lds_pkg;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } lds_spi_in_s;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lds_bus_s;

    typedef enum logic [1:0] {
        LDS_SEL_NONE,
        LDS_SEL_CONTROL,
        LDS_SEL_SPREAD
    } lds_sel_e;

endpackage : lds_pkg

// [logic/lds_serial_port.sv]
`timescale 1ns/1ps
`include "lds_defines.svh"

module lds_serial_port (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clear,
    input wire lds_pkg::lds_spi_in_s spi_in,
    input wire logic [7:0] rdata,
    output lds_pkg::lds_bus_s bus,
    output logic miso,
    output logic miso_oe_n
);

    typedef struct packed {
        logic sclk_prev;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] shift_in;
        logic is_read;
        logic inc;
        logic [7:0] miso_sh;
        logic miso;
        logic miso_oe_n;
        lds_pkg::lds_bus_s bus;
    } lds_port_s;

    lds_port_s state_reg;
    lds_port_s state_next;

    always_comb begin
        logic [7:0] byte_in;
        byte_in = {state_reg.shift_in[6:0], spi_in.mosi};
        state_next = state_reg;
        state_next.sclk_prev = spi_in.sclk;
        state_next.bus.wr = 1'b0;
        state_next.inc = 1'b0;
        if (state_reg.inc) begin
            state_next.bus.addr = state_reg.bus.addr + 8'h01;
        end
        if (spi_in.cs_n || clear) begin
            // frame end or pin rise drops any partial transfer
            state_next.bit_cnt = 3'h0;
            state_next.byte_cnt = `LDS_BYTE_CMD;
            state_next.is_read = 1'b0;
            state_next.miso = 1'b0;
            state_next.miso_oe_n = 1'b1;
        end else if (spi_in.sclk && !state_reg.sclk_prev) begin
            state_next.shift_in = byte_in;
            state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
            if (state_reg.bit_cnt == `LDS_LAST_BIT) begin
                case (state_reg.byte_cnt)
                    `LDS_BYTE_CMD: begin
                        state_next.is_read = byte_in[`LDS_CMD_READ_BIT];
                        state_next.byte_cnt = `LDS_BYTE_ADDR;
                    end
                    `LDS_BYTE_ADDR: begin
                        state_next.bus.addr = byte_in;
                        state_next.byte_cnt = `LDS_BYTE_DATA;
                    end
                    default: begin
                        state_next.bus.wr = !state_reg.is_read;
                        state_next.bus.wdata = byte_in;
                        state_next.inc = 1'b1;
                    end
                endcase
            end
        end else if (!spi_in.sclk && state_reg.sclk_prev
                     && state_reg.is_read
                     && state_reg.byte_cnt == `LDS_BYTE_DATA) begin
            state_next.miso_oe_n = 1'b0;
            if (state_reg.bit_cnt == 3'h0) begin
                state_next.miso_sh = rdata;
                state_next.miso = rdata[7];
            end else begin
                state_next.miso_sh = {state_reg.miso_sh[6:0], 1'b0};
                state_next.miso = state_reg.miso_sh[6];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.miso_oe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus = state_reg.bus;
    assign miso = state_reg.miso;
    assign miso_oe_n = state_reg.miso_oe_n;

endmodule : lds_serial_port

// [logic/lds_shutdown_ctrl.sv]
`timescale 1ns/1ps
`include "lds_defines.svh"


module lds_shutdown_ctrl #(
    parameter int CHANNELS = `LDS_CHANNELS
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hard_shutdown_pin_n,
    input wire lds_pkg::lds_spi_in_s spi_in,
    output logic miso,
    output logic miso_oe_n,
    output logic [CHANNELS-1:0] led_enable,
    output logic spread_enable,
    output logic [5:0] spread_span_pct,
    output logic soft_shutdown_active,
    output logic hard_shutdown_active
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] chip_control;
        logic [7:0] spread_spectrum_setup;
        logic pin_prev;
        logic port_clear;
        logic [CHANNELS-1:0] led_enable;
        logic spread_enable;
        logic [5:0] spread_span_pct;
        logic soft_shutdown_active;
        logic hard_shutdown_active;
    } lds_ctrl_s;

    lds_ctrl_s state_reg;
    lds_ctrl_s state_next;
    lds_pkg::lds_bus_s bus;
    logic [7:0] rdata;

    // ****************************************
    // decode
    // ****************************************
    function automatic lds_pkg::lds_sel_e reg_sel(input logic [7:0] addr);
        case (addr)
            `LDS_ADDR_CHIP_CONTROL: reg_sel = lds_pkg::LDS_SEL_CONTROL;
            `LDS_ADDR_SPREAD_SETUP: reg_sel = lds_pkg::LDS_SEL_SPREAD;
            default: reg_sel = lds_pkg::LDS_SEL_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic [5:0] span_of(input logic [1:0] range_sel);
        case (range_sel)
            2'h0: span_of = `LDS_SPAN_0;
            2'h1: span_of = `LDS_SPAN_1;
            2'h2: span_of = `LDS_SPAN_2;
            default: span_of = `LDS_SPAN_3;
        endcase
    endfunction : span_of

    // ****************************************
    // serial port
    // ****************************************
    lds_serial_port u_port (
        .mclk(mclk),
        .reset_n(reset_n),
        .clear(state_reg.port_clear),
        .spi_in(spi_in),
        .rdata(rdata),
        .bus(bus),
        .miso(miso),
        .miso_oe_n(miso_oe_n)
    );

    // reads stay live in both shutdown states
    always_comb begin
        case (reg_sel(bus.addr))
            lds_pkg::LDS_SEL_CONTROL: rdata = state_reg.chip_control;
            lds_pkg::LDS_SEL_SPREAD: rdata = state_reg.spread_spectrum_setup;
            default: rdata = 8'h00;
        endcase
    end

    // ****************************************
    // control
    // ****************************************
    always_comb begin
        logic [1:0] spread_range_sel;
        logic soft_run_n_shut;
        logic out_on;
        spread_range_sel = 2'h0;
        soft_run_n_shut = 1'b0;
        out_on = 1'b0;
        state_next = state_reg;
        state_next.pin_prev = hard_shutdown_pin_n;
        // one-cycle clear of the port on pin rise
        state_next.port_clear = hard_shutdown_pin_n
                                && !state_reg.pin_prev;
        // writes accepted regardless of shutdown state
        if (bus.wr) begin
            case (reg_sel(bus.addr))
                lds_pkg::LDS_SEL_CONTROL:
                    state_next.chip_control = bus.wdata;
                lds_pkg::LDS_SEL_SPREAD:
                    state_next.spread_spectrum_setup = bus.wdata;
                default: begin
                end
            endcase
        end
        spread_range_sel = state_next.spread_spectrum_setup[
            `LDS_RANGE_MSB:`LDS_RANGE_LSB];
        soft_run_n_shut = state_next.chip_control[`LDS_RUN_BIT];
        // shutdown gates outputs only; registers untouched
        out_on = soft_run_n_shut && hard_shutdown_pin_n;
        state_next.led_enable = {CHANNELS{out_on}};
        state_next.soft_shutdown_active = !soft_run_n_shut;
        state_next.hard_shutdown_active = !hard_shutdown_pin_n;
        state_next.spread_span_pct = span_of(spread_range_sel);
        state_next.spread_enable = out_on
            && state_next.spread_spectrum_setup[`LDS_SPREAD_EN_BIT];
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.chip_control <= `LDS_CHIP_CONTROL_RESET;
            state_reg.spread_spectrum_setup <= `LDS_SPREAD_SETUP_RESET;
            state_reg.spread_span_pct <= `LDS_SPAN_0;
            state_reg.soft_shutdown_active <= 1'b1;
            state_reg.hard_shutdown_active <= 1'b0;
            state_reg.pin_prev <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign led_enable = state_reg.led_enable;
    assign spread_enable = state_reg.spread_enable;
    assign spread_span_pct = state_reg.spread_span_pct;
    assign soft_shutdown_active = state_reg.soft_shutdown_active;
    assign hard_shutdown_active = state_reg.hard_shutdown_active;

endmodule : lds_shutdown_ctrl

// [bench/lds_shutdown_chk.sv]
`timescale 1ns/1ps
module lds_shutdown_chk #(
    parameter int CHANNELS = 18
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hard_shutdown_pin_n,
    input wire lds_pkg::lds_spi_in_s spi_in,
    input wire logic miso_oe_n,
    input wire logic [CHANNELS-1:0] led_enable,
    input wire logic spread_enable,
    input wire logic [5:0] spread_span_pct,
    input wire logic soft_shutdown_active,
    input wire logic hard_shutdown_active
);
    // ****************
    // output checks
    // ****************
    wire logic on = !soft_shutdown_active && !hard_shutdown_active;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    reset_vals_a: assert property ($rose(reset_n) |-> soft_shutdown_active
        && led_enable == '0 && spread_span_pct == 6'h05) else $error("reset");
    span_legal_a: assert property (spread_span_pct inside
        {6'h05, 6'h0F, 6'h18, 6'h22}) else $error("span");
    soft_off_a: assert property (soft_shutdown_active |->
        led_enable == '0) else $error("soft");
    hard_off_a: assert property (!hard_shutdown_pin_n |=>
        hard_shutdown_active && led_enable == '0) else $error("hard");
    pin_resume_a: assert property ($rose(hard_shutdown_pin_n) &&
        !soft_shutdown_active |=> led_enable == '1) else $error("resume");
    enable_and_a: assert property (led_enable ==
        {CHANNELS{on}}) else $error("and");
    regs_kept_a: assert property ($changed(hard_shutdown_pin_n) |=>
        $stable(spread_span_pct) && $stable(soft_shutdown_active))
        else $error("kept");
    spread_gate_a: assert property (spread_enable |-> on)
        else $error("gate");
    miso_release_a: assert property (spi_in.cs_n |=> miso_oe_n)
        else $error("release");
    cover property (hard_shutdown_active && !soft_shutdown_active);
    cover property (!miso_oe_n);
    cover property ($rose(hard_shutdown_pin_n) && !soft_shutdown_active);
endmodule : lds_shutdown_chk
bind lds_shutdown_ctrl lds_shutdown_chk #(.CHANNELS(CHANNELS)) u_chk (
    .mclk(mclk), .reset_n(reset_n), .hard_shutdown_pin_n(hard_shutdown_pin_n),
    .spi_in(spi_in), .miso_oe_n(miso_oe_n), .led_enable(led_enable),
    .spread_enable(spread_enable), .spread_span_pct(spread_span_pct),
    .soft_shutdown_active(soft_shutdown_active),
    .hard_shutdown_active(hard_shutdown_active));

// [bench/lds_host_model.sv]
`timescale 1ns/1ps
module lds_host_model (
    input wire logic mclk,
    input wire logic miso,
    output lds_pkg::lds_spi_in_s spi,
    output logic hard_shutdown_pin_n
);
    // ****************
    // mode 0 master, 4 mclk per phase
    // ****************
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic pin(input logic v);
        hard_shutdown_pin_n = v;
        tick(3);
    endtask : pin
    task automatic sel();
        spi.cs_n = 1'b0;
        tick(1);
    endtask : sel
    task automatic shift(input logic [23:0] tx, input int n,
                         output logic [7:0] rx);
        for (int i = n - 1; i >= 0; i--) begin
            spi.sclk = 1'b0;
            spi.mosi = tx[i];
            tick(4);
            rx = {rx[6:0], miso};
            spi.sclk = 1'b1;
            tick(4);
        end
    endtask : shift
    task automatic desel();
        spi.sclk = 1'b0;
        tick(2);
        spi.cs_n = 1'b1;
        spi.mosi = ~spi.mosi;
        tick(3);
    endtask : desel
    task automatic frame(input logic [23:0] tx, output logic [7:0] rx);
        sel();
        shift(tx, 24, rx);
        desel();
    endtask : frame
    initial begin
        spi = 3'b010;
        hard_shutdown_pin_n = 1'b1;
    end
endmodule : lds_host_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    localparam int CH = 18;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    lds_pkg::lds_spi_in_s spi;
    logic pin_n, miso, miso_oe_n, spr_en, soft_sd, hard_sd;
    logic [CH-1:0] led;
    logic [5:0] span;
    logic [7:0] d;
    logic [5:0] spans [4] = '{6'h05, 6'h0F, 6'h18, 6'h22};
    int failures = 0;
    int n_compared = 0;
    always #2 mclk = ~mclk;
    lds_host_model u_lds_host_model (.mclk(mclk), .miso(miso), .spi(spi),
        .hard_shutdown_pin_n(pin_n));
    lds_shutdown_ctrl #(.CHANNELS(CH)) u_lds_shutdown_ctrl (.mclk(mclk),
        .reset_n(reset_n), .hard_shutdown_pin_n(pin_n), .spi_in(spi),
        .miso(miso), .miso_oe_n(miso_oe_n), .led_enable(led),
        .spread_enable(spr_en), .spread_span_pct(span),
        .soft_shutdown_active(soft_sd), .hard_shutdown_active(hard_sd));
    task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_lds_host_model.frame({8'h00, a, v}, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_lds_host_model.frame({8'h80, a, 8'h00}, d);
        cmp(18'(d), 18'(exp));
    endtask : rd
    task automatic st(input logic on, input logic s, input logic h);
        cmp(led, {CH{on}});
        cmp(18'({soft_sd, hard_sd}), 18'({s, h}));
    endtask : st
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        st(1'b0, 1'b1, 1'b0);
        cmp(18'(span), 18'h0_0005);
        rd(8'h00, 8'h00);
        rd(8'h19, 8'h00);
        $display("reset test done");
        wr(8'h00, 8'h01);
        st(1'b1, 1'b0, 1'b0);
        for (int r = 0; r < 4; r++) begin
            wr(8'h19, 8'h80 | 8'(r));
            cmp(18'(span), 18'(spans[r]));
            cmp(18'(spr_en), 18'h0_0001);
            rd(8'h19, 8'h80 | 8'(r));
        end
        $display("range test done");
        u_lds_host_model.pin(1'b0);
        st(1'b0, 1'b0, 1'b1);
        wr(8'h19, 8'h82);
        wr(8'h00, 8'h01);
        rd(8'h19, 8'h82);
        st(1'b0, 1'b0, 1'b1);
        u_lds_host_model.pin(1'b1);
        st(1'b1, 1'b0, 1'b0);
        cmp(18'(span), 18'h0_0018);
        $display("hard shutdown test done");
        wr(8'h00, 8'h00);
        st(1'b0, 1'b1, 1'b0);
        cmp(18'(spr_en), 18'h0_0000);
        wr(8'h05, 8'hA5);
        rd(8'h05, 8'h00);
        rd(8'h19, 8'h82);
        $display("soft shutdown test done");
        u_lds_host_model.sel();
        u_lds_host_model.shift(24'h00_000F, 4, d);
        u_lds_host_model.pin(1'b0);
        u_lds_host_model.pin(1'b1);
        u_lds_host_model.shift(24'h00_1901, 24, d);
        u_lds_host_model.desel();
        cmp(18'(span), 18'h0_000F);
        rd(8'h00, 8'h00);
        $display("abort test done");
        stop_test();
    end
endmodule : tb_top
